// ---- include/scs_defines.svh ----
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// Register offsets
`define SCS_ADDR_IDENTITY 8'h0d
`define SCS_ADDR_CONTROL_ONE 8'h2a
`define SCS_ADDR_ACC_FIRST 8'h01
`define SCS_ADDR_ACC_LAST 8'h06
`define SCS_ADDR_MAG_FIRST 8'h33
`define SCS_ADDR_MAG_LAST 8'h38
`define SCS_ADDR_STEP 8'h01
`define SCS_ADDR_STEP_FAST 8'h02

// Fields of system_control_one
`define SCS_CTRL_RESET 8'h00
`define SCS_BIT_ACTIVE 0
`define SCS_BIT_FAST_READ 1
`define SCS_BIT_LOW_NOISE 2
`define SCS_RATE_LSB 3
`define SCS_RATE_MSB 5
`define SCS_SLEEP_LSB 6
`define SCS_SLEEP_MSB 7

// Identity value, arbitrary
`define SCS_IDENTITY_VALUE 8'h5a

// Timing: fastest sample period and system clock period
`define SCS_FASTEST_PERIOD_NS 1250000
`define SCS_CLK_PERIOD_NS 8
`define SCS_FASTEST_PERIOD_CYCLES (`SCS_FASTEST_PERIOD_NS / `SCS_CLK_PERIOD_NS)

// Sample period as a left shift of the fastest period
`define SCS_SHIFT_800HZ 4'h0
`define SCS_SHIFT_400HZ 4'h1
`define SCS_SHIFT_200HZ 4'h2
`define SCS_SHIFT_100HZ 4'h3
`define SCS_SHIFT_50HZ 4'h4
`define SCS_SHIFT_12HZ5 4'h6
`define SCS_SHIFT_6HZ25 4'h7
`define SCS_SHIFT_1HZ56 4'h9
`define SCS_SHIFT_HYBRID 4'h1
`define SCS_SHIFT_NONE 4'h0

`endif

// ---- include/scs_pkg.sv ----
package scs_pkg;
	typedef enum logic [1:0] {
		SCS_STANDBY,
		SCS_WAKE,
		SCS_SLEEP
	} scs_power_type;
	typedef logic [7:0] scs_byte_type;
	typedef logic [3:0] scs_shift_type;
endpackage

// ---- verilog/scs_rate_tick.sv ----
`include "scs_defines.svh"

// Free running sample tick; period is the base period shifted left
module scs_rate_tick #(
	parameter int BASE_CYCLES = `SCS_FASTEST_PERIOD_CYCLES,
	parameter int CNT_W = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire scs_pkg::scs_shift_type shift,
	output logic tick_r
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic tick_nxt;
	logic [CNT_W-1:0] limit;

	always_comb begin
		limit = (CNT_W'(BASE_CYCLES) << shift) - CNT_W'(1);
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (!run) begin
			cnt_nxt = '0;
		end else if (cnt_r >= limit) begin
			// Also restarts cleanly when the period shrinks mid count
			cnt_nxt = '0;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end
endmodule

// ---- verilog/scs_burst_ptr.sv ----
`include "scs_defines.svh"

// Register address pointer for burst reads
module scs_burst_ptr (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic advance,
	input wire scs_pkg::scs_byte_type load_addr,
	input wire logic fast_read,
	input wire logic hybrid,
	input wire logic hyb_autoinc,
	output scs_pkg::scs_byte_type ptr_nxt,
	output scs_pkg::scs_byte_type ptr_r
);
	scs_pkg::scs_byte_type step;
	scs_pkg::scs_byte_type stepped;
	logic in_acc;
	logic in_mag;
	logic chain;

	always_comb begin
		in_acc = (ptr_r >= `SCS_ADDR_ACC_FIRST) && (ptr_r <= `SCS_ADDR_ACC_LAST);
		in_mag = (ptr_r >= `SCS_ADDR_MAG_FIRST) && (ptr_r <= `SCS_ADDR_MAG_LAST);
		chain = hybrid && hyb_autoinc;
		step = `SCS_ADDR_STEP;
		if (fast_read && (in_acc || (in_mag && chain))) begin
			step = `SCS_ADDR_STEP_FAST; // see RULE_11
		end
		stepped = ptr_r + step;
		ptr_nxt = ptr_r;
		if (load) begin
			ptr_nxt = load_addr;
		end else if (advance) begin
			ptr_nxt = stepped;
			if (chain && in_acc && stepped > `SCS_ADDR_ACC_LAST) begin
				ptr_nxt = `SCS_ADDR_MAG_FIRST; // see RULE_14 see RULE_12
			end else if (chain && in_mag && stepped > `SCS_ADDR_MAG_LAST) begin
				ptr_nxt = `SCS_ADDR_ACC_FIRST;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_r <= '0;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end
endmodule

// ---- verilog/scs_sensor_ctrl.sv ----
// Notes on behaviour
// RULE_01 - A read-only eight-bit identity register sits at 0x0d and holds a fixed value.
// RULE_02 - The host puts the part in standby before changing any control field but active.
// RULE_03 - The two-bit sleep rate picks 50, 12.5, 6.25 or 1.56 Hz for auto-sleep sampling.
// RULE_04 - In auto-sleep the sleep rate replaces the selected output rate everywhere.
// RULE_05 - In hybrid operation the auto-sleep rate is half the encoded value.
// RULE_06 - The three-bit rate field picks 800 Hz down to 1.5625 Hz, 1.25 ms at the top.
// RULE_07 - Hybrid operation halves the output rate and doubles the sample period.
// RULE_08 - The active bit selects active at 1 and standby at 0 and resets to 0.
// RULE_09 - Low noise doubles the gain and is only for the 2 g or 4 g ranges.
// RULE_10 - In low noise no event with a threshold above 4 g ever triggers.
// RULE_11 - Fast read gives high bytes only and the burst pointer skips low bytes; here it skips at 0x33 to 0x38 only with hybrid chaining.
// RULE_12 - Fast read with hybrid chaining returns all high bytes in a 6-byte burst.
// RULE_13 - The host changes fast read only while the FIFO is disabled.
// RULE_14 - Hybrid chaining returns all twelve output bytes in a burst from 0x01.
// RULE_15 - While active, writes change only the active bit of the control register.
`include "scs_defines.svh"

module scs_sensor_ctrl #(
	parameter int BASE_PERIOD_CYCLES = `SCS_FASTEST_PERIOD_CYCLES,
	parameter int NUM_EVENTS = 4
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire scs_pkg::scs_byte_type REG_ADDR,
	input wire scs_pkg::scs_byte_type REG_WDATA,
	input wire logic REG_WRITE,
	input wire logic REG_READ_FIRST,
	input wire logic REG_READ_NEXT,
	input wire logic HYBRID_MODE,
	input wire logic HYBRID_AUTOINC,
	input wire logic AUTO_SLEEP,
	input wire logic [NUM_EVENTS-1:0] EVT_DETECT,
	input wire logic [NUM_EVENTS-1:0] EVT_ABOVE_4G,
	output scs_pkg::scs_byte_type REG_RDATA,
	output logic REG_RVALID,
	output logic REG_RHIT,
	output scs_pkg::scs_byte_type REG_RADDR,
	output logic ACTIVE_MODE,
	output logic FAST_READ,
	output logic LOW_NOISE_GAIN,
	output scs_pkg::scs_power_type POWER_STATE,
	output scs_pkg::scs_shift_type RATE_SHIFT,
	output logic SAMPLE_TICK,
	output logic [NUM_EVENTS-1:0] EVT_TRIGGER
);
	// Three-bit output rate code to period shift
	function automatic scs_pkg::scs_shift_type rate_shift(input logic [2:0] code);
		scs_pkg::scs_shift_type s;
		unique case (code)
			3'h0: s = `SCS_SHIFT_800HZ;
			3'h1: s = `SCS_SHIFT_400HZ;
			3'h2: s = `SCS_SHIFT_200HZ;
			3'h3: s = `SCS_SHIFT_100HZ;
			3'h4: s = `SCS_SHIFT_50HZ;
			3'h5: s = `SCS_SHIFT_12HZ5;
			3'h6: s = `SCS_SHIFT_6HZ25;
			3'h7: s = `SCS_SHIFT_1HZ56;
		endcase
		return s;
	endfunction

	// Two-bit sleep rate code to period shift
	function automatic scs_pkg::scs_shift_type sleep_shift(input logic [1:0] code);
		scs_pkg::scs_shift_type s;
		unique case (code)
			2'h0: s = `SCS_SHIFT_50HZ;
			2'h1: s = `SCS_SHIFT_12HZ5;
			2'h2: s = `SCS_SHIFT_6HZ25;
			2'h3: s = `SCS_SHIFT_1HZ56;
		endcase
		return s;
	endfunction

	// Read decode, used for the data and for the hit flag
	function automatic logic reg_hit(input scs_pkg::scs_byte_type a);
		return (a == `SCS_ADDR_IDENTITY) || (a == `SCS_ADDR_CONTROL_ONE);
	endfunction

	// Control register
	scs_pkg::scs_byte_type ctrl_r;
	scs_pkg::scs_byte_type ctrl_nxt;
	logic ctrl_active;
	logic ctrl_fast;
	logic ctrl_noise;
	logic [2:0] ctrl_rate;
	logic [1:0] ctrl_sleep;

	assign ctrl_active = ctrl_r[`SCS_BIT_ACTIVE];
	assign ctrl_fast = ctrl_r[`SCS_BIT_FAST_READ];
	assign ctrl_noise = ctrl_r[`SCS_BIT_LOW_NOISE];
	assign ctrl_rate = ctrl_r[`SCS_RATE_MSB:`SCS_RATE_LSB];
	assign ctrl_sleep = ctrl_r[`SCS_SLEEP_MSB:`SCS_SLEEP_LSB];

	always_comb begin
		ctrl_nxt = ctrl_r;
		// Writes to any other address are dropped with no answer
		if (REG_WRITE && REG_ADDR == `SCS_ADDR_CONTROL_ONE) begin
			if (ctrl_active) begin
				// Only the mode bit follows the write while sampling; see RULE_15 see RULE_02
				ctrl_nxt[`SCS_BIT_ACTIVE] = REG_WDATA[`SCS_BIT_ACTIVE];
			end else begin
				ctrl_nxt = REG_WDATA;
			end
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			ctrl_r <= `SCS_CTRL_RESET; // see RULE_08
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// Power state
	scs_pkg::scs_power_type power_r;
	scs_pkg::scs_power_type power_nxt;

	always_comb begin
		power_nxt = power_r;
		unique case (power_r)
			scs_pkg::SCS_STANDBY: begin
				if (ctrl_active) begin
					power_nxt = scs_pkg::SCS_WAKE; // see RULE_08
				end
			end
			scs_pkg::SCS_WAKE: begin
				if (!ctrl_active) begin
					power_nxt = scs_pkg::SCS_STANDBY;
				end else if (AUTO_SLEEP) begin
					power_nxt = scs_pkg::SCS_SLEEP;
				end
			end
			scs_pkg::SCS_SLEEP: begin
				if (!ctrl_active) begin
					power_nxt = scs_pkg::SCS_STANDBY;
				end else if (!AUTO_SLEEP) begin
					power_nxt = scs_pkg::SCS_WAKE;
				end
			end
			default: begin
				// Unused code falls back to standby
				power_nxt = scs_pkg::SCS_STANDBY;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			power_r <= scs_pkg::SCS_STANDBY;
		end else begin
			power_r <= power_nxt;
		end
	end

	// Effective sample period
	scs_pkg::scs_shift_type shift_r;
	scs_pkg::scs_shift_type shift_nxt;
	scs_pkg::scs_shift_type shift_base;

	always_comb begin
		if (power_r == scs_pkg::SCS_SLEEP) begin
			shift_base = sleep_shift(ctrl_sleep); // see RULE_03 see RULE_04
		end else begin
			shift_base = rate_shift(ctrl_rate); // see RULE_06
		end
		// Hybrid halves every rate, so the period doubles once more
		if (HYBRID_MODE) begin
			shift_nxt = shift_base + `SCS_SHIFT_HYBRID; // see RULE_05 see RULE_07
		end else begin
			shift_nxt = shift_base + `SCS_SHIFT_NONE;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			shift_r <= `SCS_SHIFT_NONE;
		end else begin
			shift_r <= shift_nxt;
		end
	end

	// Standby holds the tick counter cleared
	logic tick_run;
	logic tick;

	assign tick_run = power_r != scs_pkg::SCS_STANDBY;

	scs_rate_tick #(
		.BASE_CYCLES(BASE_PERIOD_CYCLES)
	) u_rate (
		.clk(CLK_SYS),
		.rst(RESET),
		.run(tick_run),
		.shift(shift_r),
		.tick_r(tick)
	);

	// Burst pointer and read data
	scs_pkg::scs_byte_type ptr_nxt;
	scs_pkg::scs_byte_type ptr_cur;

	scs_burst_ptr u_ptr (
		.clk(CLK_SYS),
		.rst(RESET),
		.load(REG_READ_FIRST),
		.advance(REG_READ_NEXT),
		.load_addr(REG_ADDR),
		.fast_read(ctrl_fast),
		.hybrid(HYBRID_MODE),
		.hyb_autoinc(HYBRID_AUTOINC),
		.ptr_nxt(ptr_nxt),
		.ptr_r(ptr_cur)
	);

	scs_pkg::scs_byte_type rdata_r;
	scs_pkg::scs_byte_type rdata_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	logic rhit_r;
	logic rhit_nxt;

	always_comb begin
		rvalid_nxt = REG_READ_FIRST || REG_READ_NEXT;
		rhit_nxt = rvalid_nxt && reg_hit(ptr_nxt);
		rdata_nxt = '0;
		// Data follows the moved pointer, so a burst returns the new address
		if (rhit_nxt) begin
			case (ptr_nxt)
				`SCS_ADDR_IDENTITY: begin
					rdata_nxt = `SCS_IDENTITY_VALUE; // see RULE_01
				end
				`SCS_ADDR_CONTROL_ONE: begin
					rdata_nxt = ctrl_r;
				end
				default: begin
					rdata_nxt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			rdata_r <= '0;
			rvalid_r <= 1'b0;
			rhit_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			rhit_r <= rhit_nxt;
		end
	end

	// Event gating; high thresholds cannot be reached with doubled gain
	logic [NUM_EVENTS-1:0] evt_r;
	logic [NUM_EVENTS-1:0] evt_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_evt
			always_comb begin
				evt_nxt[gi] = EVT_DETECT[gi] && !(ctrl_noise && EVT_ABOVE_4G[gi]); // see RULE_10
			end
		end
	endgenerate

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			evt_r <= '0;
		end else begin
			evt_r <= evt_nxt;
		end
	end

	// Output registers
	// Mode copies lag the control register by one cycle
	logic tick_r;
	logic gain_r;
	logic fast_r;

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			tick_r <= 1'b0;
			gain_r <= 1'b0;
			fast_r <= 1'b0;
		end else begin
			tick_r <= tick;
			gain_r <= ctrl_noise; // see RULE_09
			fast_r <= ctrl_fast; // see RULE_11
		end
	end

	assign REG_RDATA = rdata_r;
	assign REG_RVALID = rvalid_r;
	assign REG_RHIT = rhit_r;
	assign REG_RADDR = ptr_cur;
	assign ACTIVE_MODE = ctrl_r[`SCS_BIT_ACTIVE];
	assign FAST_READ = fast_r;
	assign LOW_NOISE_GAIN = gain_r;
	assign POWER_STATE = power_r;
	assign RATE_SHIFT = shift_r;
	assign SAMPLE_TICK = tick_r;
	assign EVT_TRIGGER = evt_r;
endmodule

// ---- tb/scs_host_model.sv ----
// Callers change fields from standby, except one write made while active to check that the fields hold
module scs_host_model (
	input wire logic clk,
	input wire scs_pkg::scs_byte_type rdata,
	output scs_pkg::scs_byte_type addr,
	output scs_pkg::scs_byte_type wdata,
	output logic wr,
	output logic rf,
	output logic rn
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rf = 1'b0;
		rn = 1'b0;
	end
	// Lines are inverted between requests so stale values never look valid
	task automatic write(input scs_pkg::scs_byte_type a, input scs_pkg::scs_byte_type d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
	task automatic read(input logic first, input scs_pkg::scs_byte_type a,
		output scs_pkg::scs_byte_type q);
		@(negedge clk);
		addr = a;
		rf = first;
		rn = ~first;
		@(negedge clk);
		rf = 1'b0;
		rn = 1'b0;
		addr = ~a;
		q = rdata;
	endtask
endmodule

// ---- tb/scs_sensor_ctrl_sva.sv ----
`include "scs_defines.svh"

module scs_sensor_ctrl_sva #(
	parameter int NUM_EVENTS = 4
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire scs_pkg::scs_byte_type REG_ADDR,
	input wire scs_pkg::scs_byte_type REG_WDATA,
	input wire logic REG_WRITE,
	input wire logic REG_READ_FIRST,
	input wire logic REG_READ_NEXT,
	input wire logic AUTO_SLEEP,
	input wire logic [NUM_EVENTS-1:0] EVT_DETECT,
	input wire logic [NUM_EVENTS-1:0] EVT_ABOVE_4G,
	input wire scs_pkg::scs_byte_type REG_RDATA,
	input wire logic REG_RVALID,
	input wire logic REG_RHIT,
	input wire scs_pkg::scs_byte_type REG_RADDR,
	input wire logic ACTIVE_MODE,
	input wire logic FAST_READ,
	input wire logic LOW_NOISE_GAIN,
	input wire scs_pkg::scs_power_type POWER_STATE,
	input wire logic SAMPLE_TICK,
	input wire logic [NUM_EVENTS-1:0] EVT_TRIGGER
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	chk_read_answer: assert property ((REG_READ_FIRST || REG_READ_NEXT) |=> REG_RVALID)
		else $error("read not answered");
	chk_identity_read: assert property ((REG_READ_FIRST && REG_ADDR == 8'h0d) |=>
		REG_RHIT && REG_RDATA == `SCS_IDENTITY_VALUE) else $error("identity wrong");
	chk_active_write: assert property ((REG_WRITE && REG_ADDR == 8'h2a) |=>
		ACTIVE_MODE == $past(REG_WDATA[0])) else $error("active bit wrong");
	chk_fields_frozen: assert property ((ACTIVE_MODE && REG_WRITE && REG_ADDR == 8'h2a) |=>
		##1 $stable(FAST_READ) && $stable(LOW_NOISE_GAIN)) else $error("field changed");
	chk_standby_state: assert property (!ACTIVE_MODE |=>
		POWER_STATE == scs_pkg::SCS_STANDBY) else $error("not standby");
	chk_standby_quiet: assert property (!ACTIVE_MODE [*3] |=> !SAMPLE_TICK)
		else $error("tick in standby");
	chk_sleep_state: assert property ((ACTIVE_MODE && AUTO_SLEEP) [*3] |=>
		POWER_STATE == scs_pkg::SCS_SLEEP) else $error("not asleep");
	chk_event_mask: assert property (LOW_NOISE_GAIN |=> !LOW_NOISE_GAIN ||
		(EVT_TRIGGER & $past(EVT_ABOVE_4G)) == '0) else $error("event not masked");
	chk_event_pass: assert property (!LOW_NOISE_GAIN |=> LOW_NOISE_GAIN ||
		EVT_TRIGGER == $past(EVT_DETECT)) else $error("event lost");
	chk_fast_step: assert property ((REG_READ_NEXT && !REG_READ_FIRST && FAST_READ &&
		!$past(REG_WRITE) && REG_RADDR == 8'h01) |=> REG_RADDR == 8'h03) else $error("no skip");
	cov_identity: cover property (REG_READ_FIRST && REG_ADDR == 8'h0d);
	cov_sleep: cover property (POWER_STATE == scs_pkg::SCS_SLEEP);
	cov_tick: cover property (SAMPLE_TICK);
endmodule

// ---- tb/scs_sensor_ctrl_bench.sv ----
`include "scs_defines.svh"

module scs_sensor_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hyb = 1'b0;
	logic ainc = 1'b0;
	logic aslp = 1'b0;
	logic [3:0] det = 4'h0;
	logic [3:0] a4g = 4'h0;
	scs_pkg::scs_byte_type addr, wdata, rdata, raddr, d;
	logic wr, rf, rn, rvalid, rhit, act, fast, lng, tick;
	scs_pkg::scs_power_type pst;
	scs_pkg::scs_shift_type rsh;
	logic [3:0] trig;
	int n_mismatch = 0;
	int num_checks = 0;
	int cnt;
	int shf[12] = '{0, 1, 2, 3, 4, 6, 7, 9, 4, 6, 7, 9};
	always #4 clk = ~clk;
	scs_host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
		.rf(rf), .rn(rn));
	scs_sensor_ctrl #(.BASE_PERIOD_CYCLES(4)) DUT (.CLK_SYS(clk), .RESET(rst), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WRITE(wr), .REG_READ_FIRST(rf), .REG_READ_NEXT(rn),
		.HYBRID_MODE(hyb), .HYBRID_AUTOINC(ainc), .AUTO_SLEEP(aslp), .EVT_DETECT(det),
		.EVT_ABOVE_4G(a4g), .REG_RDATA(rdata), .REG_RVALID(rvalid), .REG_RHIT(rhit),
		.REG_RADDR(raddr), .ACTIVE_MODE(act), .FAST_READ(fast), .LOW_NOISE_GAIN(lng),
		.POWER_STATE(pst), .RATE_SHIFT(rsh), .SAMPLE_TICK(tick), .EVT_TRIGGER(trig));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Cycles between two sample ticks
	task automatic tick_gap(output int g);
		g = 0;
		while (tick !== 1'b1 && g < 9000) begin
			@(negedge clk);
			g++;
		end
		g = 0;
		do begin
			@(negedge clk);
			g++;
		end while (tick !== 1'b1 && g < 9000);
		if (g >= 9000) begin
			n_mismatch++;
			stop_test();
		end
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		host.read(1'b1, 8'h2a, d);
		cmp(16'({act, d}), 16'h0000);
		host.write(8'h0d, 8'hff);
		host.read(1'b1, 8'h0d, d);
		cmp(16'({rvalid, rhit, d}), {8'h03, `SCS_IDENTITY_VALUE});
		host.read(1'b1, 8'h10, d);
		cmp(16'({rhit, d}), 16'h0000);
		for (int k = 0; k < 12; k++) begin
			hyb = k[0];
			aslp = (k > 7);
			d = (k > 7) ? {k[1:0], 6'h00} : {2'b00, k[2:0], 3'b000};
			host.write(8'h2a, d);
			host.write(8'h2a, d | 8'h01);
			tick_gap(cnt);
			cmp(16'(rsh), 16'(shf[k] + hyb));
			cmp(16'(cnt), 16'(4 << (shf[k] + hyb)));
			cmp(16'(pst), 16'(aslp ? scs_pkg::SCS_SLEEP : scs_pkg::SCS_WAKE));
			host.write(8'h2a, d);
		end
		aslp = 1'b0;
		host.write(8'h2a, 8'h01);
		host.write(8'h2a, 8'h07);
		host.read(1'b1, 8'h2a, d);
		cmp(16'(d), 16'h0001);
		cmp(16'({act, fast, lng}), 16'h0004);
		host.write(8'h2a, 8'h00);
		host.write(8'h2a, 8'h04);
		det = 4'hf;
		a4g = 4'h5;
		repeat (3) @(negedge clk);
		cmp(16'(trig), 16'h000a);
		cmp(16'({act, fast, lng}), 16'h0001);
		host.write(8'h2a, 8'h00);
		repeat (3) @(negedge clk);
		cmp(16'(trig), 16'h000f);
		hyb = 1'b1;
		ainc = 1'b1;
		for (int s = 2; s > 0; s--) begin
			host.write(8'h2a, {6'h00, s[1], 1'b0});
			host.read(1'b1, 8'h01, d);
			cmp(16'({act, fast}), 16'(s[1]));
			for (int i = 1; i <= 12 / s; i++) begin
				host.read(1'b0, 8'h00, d);
				cnt = (i % (12 / s)) * s;
				cmp(16'(raddr), 16'(cnt < 6 ? cnt + 1 : cnt + 45));
			end
		end
		stop_test();
	end
endmodule

bind scs_sensor_ctrl scs_sensor_ctrl_sva #(.NUM_EVENTS(NUM_EVENTS)) chk (.CLK_SYS, .RESET,
	.REG_ADDR, .REG_WDATA, .REG_WRITE, .REG_READ_FIRST, .REG_READ_NEXT, .AUTO_SLEEP,
	.EVT_DETECT, .EVT_ABOVE_4G, .REG_RDATA, .REG_RVALID, .REG_RHIT, .REG_RADDR, .ACTIVE_MODE,
	.FAST_READ, .LOW_NOISE_GAIN, .POWER_STATE, .SAMPLE_TICK, .EVT_TRIGGER);
